/* File: design/raserr_pkg.sv */
// Constants and types for the reliability error handling block
// What this block does
// - Double-bit ECC error is never corrected
// - Data RAM uncorrectable error poisons travelling chunk
// - Poison per 64 bits, L1D per 32
// - Double-bit tag RAM error invalidates line, raises interrupt
// - Single-bit ECC error reports corrected error
// - Double-bit data RAM error reports deferred
// - Double-bit tag RAM error reports uncorrected
// - External abort on listed operations reports uncorrected
// - Barrier ignores accesses unable to abort
// - Barrier neither orders nor flushes
// - Earlier system errors pended by barrier end
// - Unmasked pending error taken before barrier ends
// - Masked physical error deferred with flag set
// - Masked virtual error deferred with software syndrome
// - Deferred status EL1 up, routed when bit set
// - Recording only with protection; record every error
// - Record 0 private, core RAM errors
// - Record 1 shared, L3 and snoop filter
// - Fault irq index 0 cluster, n+1 core
// - Injection mimics real error of chosen type
// - Injection leaves RAM; real error still handled
package raserr_pkg;
    localparam int RASERR_SYN_W = 25;
    localparam int RASERR_NCORE = 4;
    localparam int RASERR_ADDR_W = 40;
    localparam int RASERR_L1D_POISON_W = 2;
    localparam int RASERR_OTH_POISON_W = 1;
    localparam int RASERR_CNT_W = 32;
    localparam logic [1:0] RASERR_SRC_L1D = 2'h0;
    localparam logic [1:0] RASERR_SRC_L2 = 2'h1;
    localparam logic [1:0] RASERR_SRC_L3 = 2'h2;
    localparam logic [1:0] RASERR_SRC_OTH = 2'h3;
    localparam logic [1:0] RASERR_SEV_NONE = 2'h0;
    localparam logic [1:0] RASERR_SEV_CE = 2'h1;
    localparam logic [1:0] RASERR_SEV_DE = 2'h2;
    localparam logic [1:0] RASERR_SEV_UE = 2'h3;
    localparam logic [1:0] RASERR_INJ_CE = 2'h0;
    localparam logic [1:0] RASERR_INJ_DE = 2'h1;
    localparam logic [1:0] RASERR_INJ_UC = 2'h2;
    localparam logic [1:0] RASERR_INJ_UR = 2'h3;
    localparam logic [1:0] RASERR_EL1 = 2'h1;
    typedef enum logic [1:0] {RASERR_BAR_IDLE, RASERR_BAR_WAIT} raserr_bar_t;
endpackage

/* File: design/raserr_top.sv */
// Error classification, poisoning, recording, injection and barrier logic
module raserr_top
    import raserr_pkg::*;
#(
    parameter int CORE_ID = 0
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic protect_impl,
    input wire logic chk_valid,
    input wire logic [1:0] chk_src,
    input wire logic chk_is_tag,
    input wire logic chk_single,
    input wire logic chk_double,
    input wire logic chk_chunk_hi,
    input wire logic [RASERR_ADDR_W-1:0] chk_addr,
    input wire logic ext_abort,
    input wire logic ext_abort_kind_ok,
    input wire logic [RASERR_ADDR_W-1:0] ext_abort_addr,
    input wire logic cluster_err,
    input wire logic [1:0] cluster_sev,
    input wire logic inj_access,
    input wire logic record_select,
    input wire logic record_control_en,
    input wire logic pseudo_fault_control_en,
    input wire logic [1:0] pseudo_fault_type,
    input wire logic [RASERR_CNT_W-1:0] countdown_load,
    input wire logic countdown_load_we,
    input wire logic barrier_req,
    input wire logic async_abort_outstanding,
    input wire logic [1:0] cur_el,
    input wire logic nonsecure,
    input wire logic hyp_abort_route_bit,
    input wire logic phys_masked,
    input wire logic virt_masked,
    input wire logic virt_pend_set,
    input wire logic [RASERR_SYN_W-1:0] virt_err_syndrome,
    input wire logic [RASERR_SYN_W-1:0] phys_syndrome,
    input wire logic disr_rd,
    output logic [RASERR_L1D_POISON_W-1:0] poison_l1d,
    output logic [RASERR_OTH_POISON_W-1:0] poison_oth,
    output logic line_invalidate,
    output logic [1:0] sev_out,
    output logic recovery_irq,
    output logic [RASERR_NCORE:0] fault_irq_n,
    output logic phys_pending,
    output logic virt_pending,
    output logic take_phys,
    output logic take_virt,
    output logic barrier_done,
    output logic [RASERR_SYN_W:0] deferred_err_status,
    output logic [RASERR_SYN_W:0] virt_deferred_err_status,
    output logic [RASERR_SYN_W:0] disr_rdata,
    output logic disr_undef,
    output logic [1:0] selected_record_status,
    output logic [RASERR_ADDR_W-1:0] selected_record_addr,
    output logic [RASERR_CNT_W-1:0] selected_inject_countdown
);
    function automatic logic [1:0] raserr_classify(input logic single, input logic dbl,
                                                    input logic is_tag, input logic [1:0] src);
        logic [1:0] s;
        s = RASERR_SEV_NONE;
        if (dbl && (src == RASERR_SRC_L1D || src == RASERR_SRC_L2 || src == RASERR_SRC_L3)) begin
            s = is_tag ? RASERR_SEV_UE : RASERR_SEV_DE;
        end else if (single) begin
            s = RASERR_SEV_CE;
        end
        return s;
    endfunction

    function automatic logic [1:0] raserr_inj_sev(input logic [1:0] t);
        logic [1:0] s;
        s = RASERR_SEV_CE;
        case (t)
            RASERR_INJ_CE: s = RASERR_SEV_CE;
            RASERR_INJ_DE: s = RASERR_SEV_DE;
            default: s = RASERR_SEV_UE;
        endcase
        return s;
    endfunction

    logic [RASERR_CNT_W-1:0] cdn_r;
    logic inj_armed_r;
    logic inj_fire;
    logic [1:0] real_sev;
    logic [1:0] eff_sev;
    logic core_evt;
    logic [1:0] rec_sev_r [2];
    logic [RASERR_ADDR_W-1:0] rec_addr_r [2];
    logic core_irq_r;
    logic cl_irq_r;
    logic phys_pend_r;
    logic virt_pend_r;
    logic [RASERR_SYN_W:0] disr_r;
    logic [RASERR_SYN_W:0] vdisr_r;
    raserr_bar_t bar_r;
    logic [1:0] sev_r;
    logic inval_r;
    logic [RASERR_L1D_POISON_W-1:0] pl1d_r;
    logic [RASERR_OTH_POISON_W-1:0] poth_r;
    logic route_virt;
    logic phys_new;

    // Injection fires only once armed by a countdown load made with record 0 selected and both enables set
    assign inj_fire = inj_armed_r && inj_access && (cdn_r == '0) && protect_impl;
    assign real_sev = chk_valid ? raserr_classify(chk_single, chk_double, chk_is_tag, chk_src)
                                : RASERR_SEV_NONE;
    // A real error outranks the injected one so it is never masked
    assign eff_sev = (real_sev != RASERR_SEV_NONE) ? real_sev :
                     (ext_abort && ext_abort_kind_ok) ? RASERR_SEV_UE :
                     inj_fire ? raserr_inj_sev(pseudo_fault_type) : RASERR_SEV_NONE;
    assign core_evt = protect_impl && (eff_sev != RASERR_SEV_NONE) &&
                      !(chk_valid && real_sev != RASERR_SEV_NONE && chk_src == RASERR_SRC_L3);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cdn_r <= '0;
            inj_armed_r <= 1'b0;
        end else if (countdown_load_we && record_select == 1'b0) begin
            cdn_r <= countdown_load;
            inj_armed_r <= record_control_en && pseudo_fault_control_en;
        end else if (inj_armed_r && inj_access) begin
            if (cdn_r != '0) begin
                cdn_r <= cdn_r - 1'b1;
            end else begin
                inj_armed_r <= 1'b0;
            end
        end
    end

    // Poison and invalidate act on real errors only; injection leaves data alone
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pl1d_r <= '0;
            poth_r <= '0;
            inval_r <= 1'b0;
            sev_r <= RASERR_SEV_NONE;
        end else begin
            pl1d_r <= '0;
            poth_r <= '0;
            inval_r <= 1'b0;
            sev_r <= protect_impl ? eff_sev : RASERR_SEV_NONE;
            if (real_sev == RASERR_SEV_DE) begin
                if (chk_src == RASERR_SRC_L1D) begin
                    pl1d_r[chk_chunk_hi] <= 1'b1;
                end else begin
                    poth_r[0] <= 1'b1;
                end
            end
            if (real_sev == RASERR_SEV_UE) begin
                inval_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rec_sev_r[0] <= RASERR_SEV_NONE;
            rec_sev_r[1] <= RASERR_SEV_NONE;
            rec_addr_r[0] <= '0;
            rec_addr_r[1] <= '0;
        end else if (protect_impl) begin
            if (core_evt) begin
                rec_sev_r[0] <= eff_sev;
                rec_addr_r[0] <= (real_sev != RASERR_SEV_NONE) ? chk_addr : ext_abort_addr;
            end
            if (cluster_err) begin
                rec_sev_r[1] <= cluster_sev;
            end else if (chk_valid && chk_src == RASERR_SRC_L3 && real_sev != RASERR_SEV_NONE) begin
                rec_sev_r[1] <= real_sev;
                rec_addr_r[1] <= chk_addr;
            end
        end
    end

    // Interrupts are level flags cleared only by reset in this block
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            core_irq_r <= 1'b0;
            cl_irq_r <= 1'b0;
        end else begin
            if (core_evt && eff_sev != RASERR_SEV_CE) begin
                core_irq_r <= 1'b1;
            end
            // Checker-seen L3 errors follow the core rule: corrected ones stay quiet
            if (protect_impl && (cluster_err || (chk_valid && chk_src == RASERR_SRC_L3 &&
                (real_sev == RASERR_SEV_DE || real_sev == RASERR_SEV_UE)))) begin
                cl_irq_r <= 1'b1;
            end
        end
    end

    generate
        for (genvar i = 0; i < RASERR_NCORE; i++) begin : g_fault
            assign fault_irq_n[i+1] = !(core_irq_r && (i == CORE_ID));
        end
    endgenerate
    assign fault_irq_n[0] = !cl_irq_r;

    // Barrier: waits only on aborts that can still arrive, never on plain accesses
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            bar_r <= RASERR_BAR_IDLE;
        end else begin
            case (bar_r)
                RASERR_BAR_IDLE: begin
                    if (barrier_req && async_abort_outstanding) begin
                        bar_r <= RASERR_BAR_WAIT;
                    end
                end
                RASERR_BAR_WAIT: begin
                    if (!async_abort_outstanding) begin
                        bar_r <= RASERR_BAR_IDLE;
                    end
                end
                default: bar_r <= RASERR_BAR_IDLE;
            endcase
        end
    end
    logic bar_resolve;
    // No flush or ordering output exists; the barrier only completes and takes or defers pending errors
    assign bar_resolve = ((bar_r == RASERR_BAR_IDLE && barrier_req) ||
                          bar_r == RASERR_BAR_WAIT) && !async_abort_outstanding;
    // Only uncorrected core errors pend; a corrected error at the barrier is no system error
    assign phys_new = core_evt && (eff_sev == RASERR_SEV_UE);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            phys_pend_r <= 1'b0;
            disr_r <= '0;
        end else if (bar_resolve && (phys_pend_r || phys_new) && phys_masked) begin
            phys_pend_r <= 1'b0;
            disr_r <= {1'b1, phys_syndrome};
        end else if (bar_resolve && take_phys) begin
            phys_pend_r <= 1'b0;
        end else if (phys_new) begin
            phys_pend_r <= 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            virt_pend_r <= 1'b0;
            vdisr_r <= '0;
        end else if (bar_resolve && (virt_pend_r || virt_pend_set) && virt_masked) begin
            virt_pend_r <= 1'b0;
            vdisr_r <= {1'b1, virt_err_syndrome};
        end else if (bar_resolve && take_virt) begin
            virt_pend_r <= 1'b0;
        end else if (virt_pend_set) begin
            virt_pend_r <= 1'b1;
        end
    end

    assign take_phys = bar_resolve && (phys_pend_r || phys_new) && !phys_masked;
    assign take_virt = bar_resolve && (virt_pend_r || virt_pend_set) && !virt_masked;
    assign barrier_done = bar_resolve;

    assign route_virt = hyp_abort_route_bit && nonsecure && (cur_el == RASERR_EL1);
    assign disr_undef = disr_rd && (cur_el < RASERR_EL1);
    assign disr_rdata = (disr_undef || !disr_rd) ? '0 : (route_virt ? vdisr_r : disr_r);

    assign poison_l1d = pl1d_r;
    assign poison_oth = poth_r;
    assign line_invalidate = inval_r;
    assign sev_out = sev_r;
    assign recovery_irq = core_irq_r;
    assign phys_pending = phys_pend_r;
    assign virt_pending = virt_pend_r;
    assign deferred_err_status = disr_r;
    assign virt_deferred_err_status = vdisr_r;
    assign selected_record_status = rec_sev_r[record_select];
    assign selected_record_addr = rec_addr_r[record_select];
    assign selected_inject_countdown = cdn_r;

    uncorr_class_a: assert property (@(posedge core_clk) disable iff (rst)
        chk_valid && protect_impl && chk_double && chk_is_tag && chk_src == RASERR_SRC_L1D
        |=> sev_r == RASERR_SEV_UE && inval_r) else $error("tag double error not UE");
    deferred_class_a: assert property (@(posedge core_clk) disable iff (rst)
        chk_valid && protect_impl && chk_double && !chk_is_tag && chk_src == RASERR_SRC_L2
        |=> sev_r == RASERR_SEV_DE && poth_r == 1'b1) else $error("data double not DE");
    corr_class_a: assert property (@(posedge core_clk) disable iff (rst)
        chk_valid && protect_impl && chk_single && !chk_double
        |=> sev_r == RASERR_SEV_CE) else $error("single error not CE");
    l1d_poison_a: assert property (@(posedge core_clk) disable iff (rst)
        chk_valid && chk_double && !chk_is_tag && chk_src == RASERR_SRC_L1D
        |=> pl1d_r[$past(chk_chunk_hi)]) else $error("L1D chunk not poisoned");
    phys_defer_a: assert property (@(posedge core_clk) disable iff (rst)
        bar_resolve && phys_pend_r && phys_masked
        |=> !phys_pend_r && disr_r[RASERR_SYN_W]) else $error("masked error not deferred");
    virt_defer_a: assert property (@(posedge core_clk) disable iff (rst)
        bar_resolve && virt_pend_r && virt_masked
        |=> vdisr_r[RASERR_SYN_W-1:0] == $past(virt_err_syndrome)) else $error("vsyn lost");
    barrier_nowait_a: assert property (@(posedge core_clk) disable iff (rst)
        bar_r == RASERR_BAR_IDLE && barrier_req && !async_abort_outstanding
        |-> barrier_done) else $error("barrier stalled");
    disr_route_a: assert property (@(posedge core_clk) disable iff (rst)
        disr_rd && route_virt |-> disr_rdata == vdisr_r) else $error("no routing");
    ext_abort_a: assert property (@(posedge core_clk) disable iff (rst)
        protect_impl && ext_abort && ext_abort_kind_ok && !chk_valid
        |=> sev_r == RASERR_SEV_UE ##1 !fault_irq_n[CORE_ID+1]) else $error("abort not UE");
    cl_irq_a: assert property (@(posedge core_clk) disable iff (rst)
        protect_impl && cluster_err |=> !fault_irq_n[0]) else $error("cluster irq idx");

    inj_c: cover property (@(posedge core_clk) disable iff (rst) inj_fire && !chk_valid);
    defer_c: cover property (@(posedge core_clk) disable iff (rst) bar_resolve && phys_pend_r);
    wait_c: cover property (@(posedge core_clk) disable iff (rst) bar_r == RASERR_BAR_WAIT);
    take_c: cover property (@(posedge core_clk) disable iff (rst) take_virt);
endmodule

/* File: dv/raserr_chk_model.sv */
// Behavioural model of the cache RAM checkers and the cluster shared unit
module raserr_chk_model
    import raserr_pkg::*;
(
    input wire logic core_clk,
    output logic chk_valid,
    output logic [1:0] chk_src,
    output logic chk_is_tag,
    output logic chk_single,
    output logic chk_double,
    output logic chk_chunk_hi,
    output logic [RASERR_ADDR_W-1:0] chk_addr,
    output logic cluster_err,
    output logic [1:0] cluster_sev
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle lines flip to the inverse so a stale value can never pass for a fresh one
    task automatic idle();
        chk_valid = 1'b0;
        cluster_err = 1'b0;
        chk_addr = ~chk_addr;
        chk_src = ~chk_src;
        chk_is_tag = ~chk_is_tag;
        chk_single = ~chk_single;
        chk_double = ~chk_double;
        chk_chunk_hi = ~chk_chunk_hi;
        cluster_sev = ~cluster_sev;
    endtask

    task automatic report(input logic [1:0] src, input logic tag, input logic dbl,
                          input logic hi, input logic [RASERR_ADDR_W-1:0] addr);
        @(negedge core_clk);
        chk_src = src;
        chk_is_tag = tag;
        chk_single = !dbl;
        chk_double = dbl;
        chk_chunk_hi = hi;
        chk_addr = addr;
        chk_valid = 1'b1;
        @(negedge core_clk);
        idle();
    endtask

    task automatic cluster(input logic [1:0] sev);
        @(negedge core_clk);
        cluster_sev = sev;
        cluster_err = 1'b1;
        @(negedge core_clk);
        idle();
    endtask

    initial begin
        chk_addr = '0;
        chk_src = 2'h0;
        chk_is_tag = 1'b0;
        chk_single = 1'b0;
        chk_double = 1'b0;
        chk_chunk_hi = 1'b0;
        cluster_sev = 2'h0;
        idle();
    end
endmodule

/* File: dv/raserr_bench.sv */
// Self-checking bench for the reliability error handling block
module raserr_bench
    import raserr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic core_clk = 1'b0, rst = 1'b1, protect_impl = 1'b1, ext_abort = 1'b0;
    logic ext_abort_kind_ok = 1'b0, inj_access = 1'b0, record_select = 1'b0;
    logic record_control_en = 1'b0, pseudo_fault_control_en = 1'b0, countdown_load_we = 1'b0;
    logic barrier_req = 1'b0, async_abort_outstanding = 1'b0, nonsecure = 1'b1;
    logic hyp_abort_route_bit = 1'b0, phys_masked = 1'b0, virt_masked = 1'b0;
    logic virt_pend_set = 1'b0, disr_rd = 1'b0;
    logic [1:0] pseudo_fault_type = 2'h0, cur_el = 2'h1;
    logic [RASERR_ADDR_W-1:0] ext_abort_addr = '0;
    logic [RASERR_CNT_W-1:0] countdown_load = '0;
    logic [RASERR_SYN_W-1:0] virt_err_syndrome = '0, phys_syndrome = '0;
    logic chk_valid, chk_is_tag, chk_single, chk_double, chk_chunk_hi, cluster_err;
    logic line_invalidate, recovery_irq, phys_pending, virt_pending, take_phys, take_virt;
    logic barrier_done, disr_undef;
    logic [1:0] chk_src, cluster_sev, sev_out, selected_record_status;
    logic [RASERR_ADDR_W-1:0] chk_addr, selected_record_addr;
    logic [RASERR_CNT_W-1:0] selected_inject_countdown;
    logic [RASERR_SYN_W:0] deferred_err_status, virt_deferred_err_status, disr_rdata, exp_def;
    logic [RASERR_L1D_POISON_W-1:0] poison_l1d;
    logic [RASERR_OTH_POISON_W-1:0] poison_oth;
    logic [RASERR_NCORE:0] fault_irq_n;
    logic [RASERR_ADDR_W-1:0] addr;
    logic hi;
    logic [1:0] exp_s;
    logic [1:0] inj_exp[$] = '{RASERR_SEV_CE, RASERR_SEV_DE, RASERR_SEV_UE, RASERR_SEV_UE};
    int bad_count = 0, tests_run = 0, cycles = 0;

    // Core 1 so that its fault line sits at index 2, away from the cluster line
    raserr_top #(.CORE_ID(1)) dut (.*);
    raserr_chk_model partner (.*);

    always #4 core_clk = ~core_clk;

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic do_reset();
        @(negedge core_clk);
        rst = 1'b1;
        repeat (2) @(negedge core_clk);
        rst = 1'b0;
        check("irq after reset", fault_irq_n, 5'h1F);
    endtask

    task automatic pulse(ref logic sig);
        @(negedge core_clk);
        sig = 1'b1;
        @(negedge core_clk);
        sig = 1'b0;
    endtask

    function automatic logic [1:0] exp_sev(input int tag, input int dbl);
        if (dbl == 0) return RASERR_SEV_CE;
        return (tag != 0) ? RASERR_SEV_UE : RASERR_SEV_DE;
    endfunction

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 4000) begin
            bad_count++;
            final_report();
        end
    end

    initial begin
        void'($urandom(81));
        for (int s = 0; s < 3; s++) begin
            for (int k = 0; k < 4; k++) begin
                do_reset();
                // L3 errors land in the shared record only
                record_select = (s == 2);
                addr = 40'({$urandom, $urandom});
                hi = 1'($urandom);
                partner.report(2'(s), k[0], k[1], hi, addr);
                exp_s = exp_sev(k[0], k[1]);
                check("sev", sev_out, exp_s);
                check("rec sev", selected_record_status, exp_s);
                check("poison l1d", poison_l1d,
                      (s == 0 && k == 2) ? (2'h1 << hi) : 2'h0);
                check("poison other", poison_oth, s != 0 && k == 2);
                check("invalidate", line_invalidate, k == 3);
                check("record addr", selected_record_addr, addr);
                @(negedge core_clk);
                check("recovery irq", recovery_irq, s != 2 && k[1]);
                check("fault irq", fault_irq_n,
                      k[1] ? ((s == 2) ? 5'h1E : 5'h1B) : 5'h1F);
            end
        end
        do_reset();
        record_select = 1'b1;
        partner.cluster(RASERR_SEV_UE);
        check("cluster rec", selected_record_status, RASERR_SEV_UE);
        @(negedge core_clk);
        check("cluster irq", fault_irq_n, 5'h1E);
        record_select = 1'b0;
        $display("test classification done");
        for (int k = 0; k < 3; k++) begin
            do_reset();
            protect_impl = (k != 2);
            ext_abort_kind_ok = (k != 1);
            ext_abort_addr = 40'({$urandom, $urandom});
            pulse(ext_abort);
            check("abort sev", sev_out,
                  (k == 0) ? RASERR_SEV_UE : RASERR_SEV_NONE);
            check("abort pending", phys_pending, k == 0);
            check("abort addr", selected_record_addr,
                  (k == 0) ? ext_abort_addr : 40'h0);
        end
        protect_impl = 1'b1;
        $display("test external abort done");
        for (int m = 0; m < 4; m++) begin
            do_reset();
            ext_abort_kind_ok = 1'b1;
            phys_syndrome = 25'($urandom);
            virt_err_syndrome = 25'($urandom);
            phys_masked = m[0];
            virt_masked = m[0];
            async_abort_outstanding = m[1];
            exp_def = m[0] ? {1'b1, phys_syndrome} : '0;
            pulse(ext_abort);
            pulse(virt_pend_set);
            check("phys pending", phys_pending, 1'b1);
            check("virt pending", virt_pending, 1'b1);
            @(negedge core_clk);
            barrier_req = 1'b1;
            #1;
            check("barrier done", barrier_done, !m[1]);
            if (m[1] == 0) begin
                check("take phys", take_phys, !m[0]);
                check("take virt", take_virt, !m[0]);
            end
            @(negedge core_clk);
            barrier_req = 1'b0;
            if (m[1] == 1) begin
                async_abort_outstanding = 1'b0;
                #1;
                check("late done", barrier_done, 1'b1);
            end
            @(negedge core_clk);
            // Taken or deferred, nothing stays pending after the barrier
            check("phys cleared", phys_pending, 1'b0);
            check("virt cleared", virt_pending, 1'b0);
            check("deferred", deferred_err_status, exp_def);
            check("virt syndrome", virt_deferred_err_status[RASERR_SYN_W-1:0],
                  m[0] ? virt_err_syndrome : '0);
            for (int j = 0; j < 3; j++) begin
                @(negedge core_clk);
                cur_el = (j == 0) ? 2'h0 : RASERR_EL1;
                hyp_abort_route_bit = (j == 2);
                disr_rd = 1'b1;
                #1;
                check("disr undef", disr_undef, j == 0);
                check("disr read", (j == 2) ? disr_rdata[RASERR_SYN_W-1:0] : disr_rdata,
                      (j == 0) ? '0 : (j == 1) ? exp_def :
                      (m[0] ? virt_err_syndrome : '0));
            end
            disr_rd = 1'b0;
        end
        $display("test barrier done");
        for (int t = 0; t < 6; t++) begin
            do_reset();
            record_control_en = (t != 4);
            pseudo_fault_control_en = 1'b1;
            pseudo_fault_type = (t == 5) ? RASERR_INJ_DE : 2'(t);
            countdown_load = $urandom;
            pulse(countdown_load_we);
            check("countdown", selected_inject_countdown, countdown_load);
            countdown_load = '0;
            pulse(countdown_load_we);
            if (t == 5) begin
                fork
                    partner.report(RASERR_SRC_L2, 1'b0, 1'b0, 1'b0, addr);
                    pulse(inj_access);
                join
                check("real beats inject", sev_out, RASERR_SEV_CE);
                check("real logged", selected_record_status, RASERR_SEV_CE);
            end else begin
                pulse(inj_access);
                exp_s = (t == 4) ? RASERR_SEV_NONE : inj_exp[t];
                check("inject sev", sev_out, exp_s);
                check("inject logged", selected_record_status, exp_s);
                check("inject pending", phys_pending, t == 2 || t == 3);
            end
        end
        $display("test injection done");
        final_report();
    end
endmodule
